// ==== src/serial_frame_exchange_bridge.sv ====
// Serial frame exchange bridge: receive framer, image packer, transmitter, register slave
`timescale 1ns/1ps
module serial_frame_exchange_bridge
    import serial_frame_exchange_pkg::*;
#(
    parameter int CYC_PER_MS = CYCLES_PER_MS
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    output logic rx_ready,
    output logic tx_valid,
    output logic [7:0] tx_data,
    input wire logic tx_ready,
    input wire logic out_wr_en,
    input wire logic [7:0] out_wr_addr,
    input wire logic [7:0] out_wr_data,
    input wire logic [7:0] in_rd_addr,
    output logic [7:0] in_rd_data
);

    localparam int MAX_PAYLOAD = IMG_BYTES - 2;
    localparam logic [7:0] LAST_IDX = 8'(IMG_BYTES - 1);
    localparam logic [7:0] MAX_PL = 8'(MAX_PAYLOAD);
    localparam logic [15:0] MS_LAST = 16'(CYC_PER_MS - 1);
    typedef enum logic [1:0] {RX_GATHER, RX_CHECK, RX_PACK} rx_state_type;
    typedef enum logic {TX_IDLE, TX_SEND} tx_state_type;
    function automatic logic [15:0] crc16_byte(input logic [15:0] crc, input logic [7:0] b);
        logic [15:0] c;
        c = crc ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction
    cfg_type cfg_q;
    rx_state_type rx_state_q;
    tx_state_type tx_state_q;
    logic [7:0] in_img [IMG_BYTES];
    logic [7:0] out_img [IMG_BYTES];
    logic [7:0] rx_buf [MAX_PAYLOAD];
    logic [7:0] rx_cnt_q, plen_q, pack_idx_q, in_tn_q, last_tn_q, tx_idx_q, tx_left_q;
    logic [15:0] crc_q, pre_q, ms_q, per_pre_q, per_ms_q, drops_q;
    logic in_frame_q, overflow_q, by_timeout_q, period_pend_q, wr_pend_q;
    logic [31:0] rd_word;
    logic rx_take, crc_active, timer_on, timeout, period_tick, tx_start, accept;
    logic [7:0] wr_addr_q, tx_len, accept_len, pack_byte, pack_off;

    // Register slave: zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (haddr[7:0])
            REG_CTRL: rd_word = {28'h0000000, cfg_q.auto_en, cfg_q.crc_en, cfg_q.mode};
            REG_TIMEOUT: rd_word = {16'h0000, cfg_q.timeout_ms};
            REG_FRAME_LEN: rd_word = {24'h000000, cfg_q.frame_len};
            REG_DELIM: rd_word = {16'h0000, cfg_q.end_byte, cfg_q.start_byte};
            REG_PERIOD: rd_word = {16'h0000, cfg_q.period_ms};
            REG_STATUS: rd_word = {14'h0000, tx_state_q == TX_SEND,
                (rx_cnt_q != 8'h00) || in_frame_q || (rx_state_q != RX_GATHER),
                last_tn_q, in_tn_q};
            REG_DROPS: rd_word = {16'h0000, drops_q};
            default: rd_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            hrdata <= 32'h0000_0000;
        end else begin
            wr_pend_q <= hready && hsel && htrans[1] && hwrite;
            if (hready && hsel && htrans[1]) begin
                wr_addr_q <= haddr[7:0];
                hrdata <= hwrite ? 32'h0000_0000 : rd_word;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_q.mode <= 2'(MODE_TIMEOUT);
            cfg_q.crc_en <= 1'b0;
            cfg_q.auto_en <= 1'b0;
            cfg_q.timeout_ms <= TIMEOUT_DEFAULT_MS;
            cfg_q.frame_len <= FRAME_LEN_DEFAULT;
            cfg_q.start_byte <= START_DEFAULT;
            cfg_q.end_byte <= END_DEFAULT;
            cfg_q.period_ms <= PERIOD_DEFAULT_MS;
        end else if (wr_pend_q) begin
            unique case (wr_addr_q)
                REG_CTRL: begin
                    cfg_q.mode <= hwdata[CTRL_MODE_LSB +: 2];
                    cfg_q.crc_en <= hwdata[CTRL_CRC_BIT];
                    cfg_q.auto_en <= hwdata[CTRL_AUTO_BIT];
                end
                REG_TIMEOUT: cfg_q.timeout_ms <= hwdata[15:0];
                REG_FRAME_LEN: begin
                    // Out-of-range lengths are ignored, old value kept
                    if (hwdata[31:8] == 24'h000000 && hwdata[7:0] >= FRAME_LEN_MIN
                        && hwdata[7:0] <= FRAME_LEN_MAX) begin
                        cfg_q.frame_len <= hwdata[7:0];
                    end
                end
                REG_DELIM: begin
                    cfg_q.start_byte <= hwdata[7:0];
                    cfg_q.end_byte <= hwdata[DELIM_END_LSB +: 8];
                end
                REG_PERIOD: cfg_q.period_ms <= hwdata[15:0];
                default: ;
            endcase
        end
    end

    // Fieldbus side images
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < IMG_BYTES; i++) begin
                out_img[i] <= 8'h00;
            end
        end else if (out_wr_en && out_wr_addr <= LAST_IDX) begin
            out_img[out_wr_addr] <= out_wr_data;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            in_rd_data <= 8'h00;
        end else begin
            in_rd_data <= (in_rd_addr <= LAST_IDX) ? in_img[in_rd_addr] : 8'h00;
        end
    end

    // Receive framer
    assign rx_ready = (rx_state_q == RX_GATHER);
    assign rx_take = rx_valid && rx_ready;
    assign crc_active = cfg_q.crc_en && (cfg_q.mode != 2'(MODE_DELIM));
    assign timer_on = (rx_cnt_q != 8'h00) || in_frame_q;
    assign timeout = timer_on && (ms_q >= cfg_q.timeout_ms);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pre_q <= 16'h0000;
            ms_q <= 16'h0000;
        end else if (rx_take || !timer_on || rx_state_q != RX_GATHER) begin
            pre_q <= 16'h0000;
            ms_q <= 16'h0000;
        end else if (pre_q == MS_LAST) begin
            pre_q <= 16'h0000;
            ms_q <= ms_q + 16'h0001;
        end else begin
            pre_q <= pre_q + 16'h0001;
        end
    end

    always_ff @(posedge hclk) begin
        if (rx_take && rx_cnt_q < MAX_PL && !(cfg_q.mode == 2'(MODE_DELIM)
            && (!in_frame_q || rx_data == cfg_q.end_byte))) begin
            rx_buf[rx_cnt_q] <= rx_data;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_state_q <= RX_GATHER;
            rx_cnt_q <= 8'h00;
            crc_q <= CRC_INIT;
            in_frame_q <= 1'b0;
            overflow_q <= 1'b0;
            by_timeout_q <= 1'b0;
        end else begin
            unique case (rx_state_q)
                RX_GATHER: begin
                    if (rx_take) begin
                        if (cfg_q.mode == 2'(MODE_DELIM)) begin
                            if (!in_frame_q) begin
                                in_frame_q <= (rx_data == cfg_q.start_byte);
                            end else if (rx_data == cfg_q.end_byte) begin
                                by_timeout_q <= 1'b0;
                                rx_state_q <= RX_CHECK;
                            end else if (rx_cnt_q < MAX_PL) begin
                                rx_cnt_q <= rx_cnt_q + 8'h01;
                            end else begin
                                overflow_q <= 1'b1;
                            end
                        end else begin
                            crc_q <= crc16_byte(crc_q, rx_data);
                            if (rx_cnt_q < MAX_PL) begin
                                rx_cnt_q <= rx_cnt_q + 8'h01;
                            end else begin
                                overflow_q <= 1'b1;
                            end
                            if (cfg_q.mode == 2'(MODE_LENGTH)
                                && rx_cnt_q + 8'h01 == cfg_q.frame_len) begin
                                by_timeout_q <= 1'b0;
                                rx_state_q <= RX_CHECK;
                            end
                        end
                    end else if (timeout) begin
                        by_timeout_q <= 1'b1;
                        rx_state_q <= RX_CHECK;
                    end
                end
                RX_CHECK: rx_state_q <= accept ? RX_PACK : RX_GATHER;
                RX_PACK: rx_state_q <= (pack_idx_q == 8'h00) ? RX_GATHER : RX_PACK;
                default: rx_state_q <= RX_GATHER;
            endcase
            // Frame bookkeeping cleared whenever the framer goes back to gathering
            if ((rx_state_q == RX_CHECK && !accept)
                || (rx_state_q == RX_PACK && pack_idx_q == 8'h00)) begin
                rx_cnt_q <= 8'h00;
                crc_q <= CRC_INIT;
                in_frame_q <= 1'b0;
                overflow_q <= 1'b0;
            end
        end
    end

    // Frame verdict on close
    always_comb begin
        accept = 1'b0;
        accept_len = rx_cnt_q;
        if (!overflow_q) begin
            if (cfg_q.mode == 2'(MODE_DELIM)) begin
                accept = !by_timeout_q;
            end else if (cfg_q.mode == 2'(MODE_LENGTH)) begin
                accept = (rx_cnt_q == cfg_q.frame_len);
            end else begin
                accept = (rx_cnt_q != 8'h00);
            end
            if (crc_active) begin
                // Residue of the whole frame is zero when the trailing pair matches
                accept = accept && (rx_cnt_q >= 8'h02) && (crc_q == CRC_GOOD);
                accept_len = rx_cnt_q - 8'h02;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            drops_q <= 16'h0000;
        end else if (rx_state_q == RX_CHECK && !accept && drops_q != 16'hFFFF) begin
            drops_q <= drops_q + 16'h0001;
        end
    end

    // Image packer walks downward so the number byte lands last
    assign pack_off = pack_idx_q - 8'h02;
    always_comb begin
        if (pack_idx_q == 8'h00) begin
            pack_byte = in_tn_q + 8'h01;
        end else if (pack_idx_q == 8'h01) begin
            pack_byte = plen_q;
        end else if (pack_off < plen_q) begin
            pack_byte = rx_buf[pack_off];
        end else begin
            pack_byte = 8'h00;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            plen_q <= 8'h00;
            pack_idx_q <= 8'h00;
        end else if (rx_state_q == RX_CHECK) begin
            plen_q <= accept_len;
            pack_idx_q <= LAST_IDX;
        end else if (rx_state_q == RX_PACK && pack_idx_q != 8'h00) begin
            pack_idx_q <= pack_idx_q - 8'h01;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < IMG_BYTES; i++) begin
                in_img[i] <= 8'h00;
            end
            in_tn_q <= 8'h00;
        end else if (rx_state_q == RX_PACK) begin
            in_img[pack_idx_q] <= pack_byte;
            if (pack_idx_q == 8'h00) begin
                in_tn_q <= pack_byte;
            end
        end
    end

    // Transmit side, independent of receive mode
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            per_pre_q <= 16'h0000;
            per_ms_q <= 16'h0000;
        end else if (!cfg_q.auto_en || period_tick) begin
            per_pre_q <= 16'h0000;
            per_ms_q <= 16'h0000;
        end else if (per_pre_q == MS_LAST) begin
            per_pre_q <= 16'h0000;
            per_ms_q <= per_ms_q + 16'h0001;
        end else begin
            per_pre_q <= per_pre_q + 16'h0001;
        end
    end

    assign period_tick = cfg_q.auto_en && (per_ms_q + 16'h0001 >= cfg_q.period_ms)
        && (per_pre_q == MS_LAST);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            period_pend_q <= 1'b0;
        end else if (period_tick) begin
            period_pend_q <= cfg_q.auto_en;
        end else if (tx_start || !cfg_q.auto_en) begin
            period_pend_q <= 1'b0;
        end
    end
    assign tx_start = (tx_state_q == TX_IDLE)
        && (cfg_q.auto_en ? period_pend_q : (out_img[0] != last_tn_q));
    // A length beyond the image is cut to what the image can hold
    assign tx_len = (out_img[1] > MAX_PL) ? MAX_PL : out_img[1];
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_state_q <= TX_IDLE;
            tx_valid <= 1'b0;
            tx_data <= 8'h00;
            tx_idx_q <= 8'h00;
            tx_left_q <= 8'h00;
            last_tn_q <= 8'h00;
        end else begin
            unique case (tx_state_q)
                TX_IDLE: begin
                    if (tx_start) begin
                        last_tn_q <= out_img[0];
                        if (tx_len != 8'h00) begin
                            tx_state_q <= TX_SEND;
                            tx_valid <= 1'b1;
                            tx_data <= out_img[2];
                            tx_idx_q <= 8'h03;
                            tx_left_q <= tx_len;
                        end
                    end
                end
                TX_SEND: begin
                    if (tx_ready) begin
                        if (tx_left_q == 8'h01) begin
                            tx_valid <= 1'b0;
                            tx_state_q <= TX_IDLE;
                        end else begin
                            tx_data <= out_img[tx_idx_q];
                            tx_idx_q <= tx_idx_q + 8'h01;
                            tx_left_q <= tx_left_q - 8'h01;
                        end
                    end
                end
            endcase
        end
    end

endmodule // serial_frame_exchange_bridge

// ==== inc/serial_frame_exchange_pkg.sv ====
// Constants, types and register map of the serial frame exchange bridge
package serial_frame_exchange_pkg;

    localparam int CLK_PERIOD_NS = 100;
    localparam int MS_IN_NS = 1000000;
    localparam int CYCLES_PER_MS = MS_IN_NS / CLK_PERIOD_NS;

    localparam int IMG_BYTES = 168;

    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_TIMEOUT = 8'h04;
    localparam logic [7:0] REG_FRAME_LEN = 8'h08;
    localparam logic [7:0] REG_DELIM = 8'h0C;
    localparam logic [7:0] REG_PERIOD = 8'h10;
    localparam logic [7:0] REG_STATUS = 8'h14;
    localparam logic [7:0] REG_DROPS = 8'h18;

    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_CRC_BIT = 2;
    localparam int CTRL_AUTO_BIT = 3;
    localparam int DELIM_END_LSB = 8;
    localparam int STAT_OUT_TN_LSB = 8;
    localparam int STAT_RX_BUSY_BIT = 16;
    localparam int STAT_TX_BUSY_BIT = 17;

    localparam logic [15:0] TIMEOUT_DEFAULT_MS = 16'h000A;
    localparam logic [15:0] PERIOD_DEFAULT_MS = 16'h03E8;
    localparam logic [7:0] FRAME_LEN_MIN = 8'h01;
    localparam logic [7:0] FRAME_LEN_MAX = 8'hA6;
    localparam logic [7:0] FRAME_LEN_DEFAULT = 8'h01;
    localparam logic [7:0] START_DEFAULT = 8'h00;
    localparam logic [7:0] END_DEFAULT = 8'h00;

    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'hA001;
    localparam logic [15:0] CRC_GOOD = 16'h0000;

    typedef enum logic [1:0] {
        MODE_TIMEOUT,
        MODE_LENGTH,
        MODE_DELIM
    } rx_mode_type;

    typedef struct packed {
        logic [1:0] mode;
        logic crc_en;
        logic auto_en;
        logic [15:0] timeout_ms;
        logic [7:0] frame_len;
        logic [7:0] start_byte;
        logic [7:0] end_byte;
        logic [15:0] period_ms;
    } cfg_type;

endpackage

// ==== bench/serial_frame_exchange_asserts.sv ====
// Port-level concurrent checks for the serial frame exchange bridge
`timescale 1ns/1ps
module serial_frame_exchange_asserts (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic rx_ready,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_ready,
    input wire logic [7:0] in_rd_addr,
    input wire logic [7:0] in_rd_data
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Length of each receive busy stretch: check alone, or check plus pack
    logic [7:0] low_cnt_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            low_cnt_q <= 8'h00;
        end else if (rx_ready) begin
            low_cnt_q <= 8'h00;
        end else begin
            low_cnt_q <= low_cnt_q + 8'h01;
        end
    end

    ready_always_a: assert property (hreadyout == 1'b1)
        else $error("hreadyout went low");
    okay_resp_a: assert property (hresp == 1'b0)
        else $error("hresp not OKAY");
    tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("tx byte changed before accept");
    tx_end_a: assert property ($fell(tx_valid) |-> $past(tx_ready))
        else $error("tx offer withdrawn unaccepted");
    img_range_a: assert property (in_rd_addr > 8'hA7 |=> in_rd_data == 8'h00)
        else $error("read beyond image not zero");
    rx_return_a: assert property (!rx_ready |-> ##[1:200] rx_ready)
        else $error("receiver stuck busy");
    busy_len_a: assert property ($rose(rx_ready) |->
        low_cnt_q == 8'h01 || low_cnt_q inside {[8'hA8:8'hAA]})
        else $error("receive busy stretch has wrong length");
    tx_quiet_a: assert property ($rose(hresetn) |-> !tx_valid ##1 !tx_valid)
        else $error("tx started right after reset");

    cover property ($rose(rx_ready) && low_cnt_q > 8'h10);
    cover property ($rose(rx_ready) && low_cnt_q == 8'h01);
    cover property (tx_valid && !tx_ready);
endmodule // serial_frame_exchange_asserts

// ==== bench/serial_user_device.sv ====
// Behavioural user serial device: byte source and stalling byte sink
`timescale 1ns/1ps
module serial_user_device (
    input wire logic clk,
    input wire logic rx_ready,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic tx_ready
);
    logic stall = 1'b0;
    logic [7:0] got[$];
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h5A;
        tx_ready = 1'b1;
    end
    // Back-to-back bytes stay far inside the character interval
    task automatic send(input logic [7:0] b);
        @(posedge clk);
        rx_valid <= 1'b1;
        rx_data <= b;
        do @(posedge clk); while (rx_ready !== 1'b1);
        rx_valid <= 1'b0;
        // Released line shows the inverse, never the stale byte
        rx_data <= ~b;
    endtask
    always @(posedge clk) begin
        if (tx_valid === 1'b1 && tx_ready === 1'b1) got.push_back(tx_data);
        tx_ready <= stall ? ~tx_ready : 1'b1;
    end
endmodule // serial_user_device

// ==== bench/serial_frame_exchange_bridge_test.sv ====
// Self-checking bench for the serial frame exchange bridge
`timescale 1ns/1ps
module serial_frame_exchange_bridge_test;
    import serial_frame_exchange_pkg::*;
    localparam int CPM = 10;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic rx_valid, rx_ready, tx_valid, tx_ready, out_wr_en;
    logic [7:0] rx_data, tx_data, out_wr_addr, out_wr_data, in_rd_addr, in_rd_data;
    logic [7:0] tn = 8'h00;
    logic [7:0] q[$];
    logic [7:0] f[$];
    logic [15:0] c;
    int failures = 0;
    int check_count = 0;
    assign hready = hreadyout;

    serial_frame_exchange_bridge #(.CYC_PER_MS(CPM)) dut_u (.hclk, .hresetn, .hsel, .haddr,
        .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .rx_valid,
        .rx_data, .rx_ready, .tx_valid, .tx_data, .tx_ready, .out_wr_en, .out_wr_addr,
        .out_wr_data, .in_rd_addr, .in_rd_data);
    serial_user_device dev_u (.clk(hclk), .rx_ready, .tx_valid, .tx_data, .rx_valid,
        .rx_data, .tx_ready);

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h000000, a};
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
        ahb(1'b0, a, 32'h00000000);
        chk(what, exp, rd);
    endtask
    task automatic owr(input logic [7:0] a, input logic [7:0] d);
        @(posedge hclk);
        out_wr_en <= 1'b1;
        out_wr_addr <= a;
        out_wr_data <= d;
        @(posedge hclk);
        out_wr_en <= 1'b0;
    endtask
    function automatic logic [15:0] crc(input logic [7:0] b[$]);
        logic [15:0] x = CRC_INIT;
        foreach (b[i]) begin
            x = x ^ {8'h00, b[i]};
            for (int k = 0; k < 8; k++) x = x[0] ? (x >> 1) ^ CRC_POLY : x >> 1;
        end
        return x;
    endfunction
    // Waits out the character timeout plus check and pack
    task automatic frame(input logic [7:0] b[$]);
        foreach (b[i]) dev_u.send(b[i]);
        repeat (10 * CPM + 250) @(posedge hclk);
    endtask
    // Whole image plus two bytes past its end, against tn and payload q
    task automatic img(input string what);
        logic [7:0] e;
        for (int i = 0; i < IMG_BYTES + 2; i++) begin
            e = (i == 0) ? tn : (i == 1) ? 8'(q.size()) : (i < q.size() + 2) ? q[i-2] : 8'h00;
            @(posedge hclk);
            in_rd_addr <= 8'(i);
            @(posedge hclk);
            @(posedge hclk);
            chk(what, {24'h000000, e}, {24'h000000, in_rd_data});
        end
    endtask
    task automatic txwait(input int n);
        int k;
        k = 0;
        while (dev_u.got.size() < n && k < 2000) begin
            @(posedge hclk);
            k++;
        end
        repeat (30) @(posedge hclk);
    endtask

    task automatic t_regs;
        rchk(REG_CTRL, 32'h00000000, "ctrl");
        rchk(REG_TIMEOUT, 32'h0000000A, "timeout");
        rchk(REG_FRAME_LEN, 32'h00000001, "frame_len");
        rchk(REG_PERIOD, 32'h000003E8, "period");
        rchk(8'h1C, 32'h00000000, "unmapped");
        ahb(1'b1, REG_FRAME_LEN, 32'h000000A7);
        rchk(REG_FRAME_LEN, 32'h00000001, "len_over");
        ahb(1'b1, REG_FRAME_LEN, 32'h000000A6);
        rchk(REG_FRAME_LEN, 32'h000000A6, "len_max");
        ahb(1'b1, REG_FRAME_LEN, 32'h00000000);
        rchk(REG_FRAME_LEN, 32'h000000A6, "len_zero");
        $display("done regs");
    endtask
    task automatic t_timeout;
        q = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66};
        frame(q);
        tn++;
        img("img_six");
        q = '{8'hF1, 8'hF2, 8'hF1};
        frame(q);
        tn++;
        img("img_three");
        $display("done timeout");
    endtask
    task automatic t_crc;
        ahb(1'b1, REG_CTRL, 32'h00000004);
        q = '{8'h01, 8'h02, 8'h03};
        c = crc(q);
        f = {q, c[7:0], c[15:8]};
        frame(f);
        tn++;
        img("img_crc");
        f = {q, c[7:0], ~c[15:8]};
        frame(f);
        img("img_crc_bad");
        $display("done crc");
    endtask
    task automatic t_length;
        ahb(1'b1, REG_CTRL, 32'h00000001);
        ahb(1'b1, REG_FRAME_LEN, 32'h00000004);
        q = '{8'h11, 8'h22, 8'h33, 8'h44};
        frame(q);
        tn++;
        img("img_len");
        frame('{8'hAA, 8'hBB});
        img("img_len_short");
        $display("done length");
    endtask
    task automatic t_delim;
        ahb(1'b1, REG_DELIM, 32'h0000FEFF);
        ahb(1'b1, REG_CTRL, 32'h00000006);
        frame('{8'hFF, 8'h77});
        q = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55};
        f = {8'h00, 8'hFF, q, 8'hFE};
        frame(f);
        tn++;
        img("img_delim");
        ahb(1'b0, REG_STATUS, 32'h00000000);
        chk("in_tn", {24'h000000, tn}, {24'h000000, rd[7:0]});
        rchk(REG_DROPS, 32'h00000003, "drops");
        $display("done delim");
    endtask
    task automatic t_tx;
        dev_u.stall = 1'b1;
        q = '{8'h00, 8'h02, 8'h08, 8'h45, 8'h96};
        owr(8'h01, 8'h05);
        foreach (q[i]) owr(8'(i + 2), q[i]);
        owr(8'h07, 8'h00);
        dev_u.got.delete();
        owr(8'h00, 8'h09);
        txwait(5);
        chk("tx_count", 32'h00000005, 32'(dev_u.got.size()));
        foreach (q[i]) chk("tx_byte", {24'h000000, q[i]}, {24'h000000, dev_u.got[i]});
        ahb(1'b0, REG_STATUS, 32'h00000000);
        chk("sent_tn", 32'h00000009, {24'h000000, rd[15:8]});
        $display("done tx");
    endtask
    task automatic t_auto;
        dev_u.stall = 1'b0;
        ahb(1'b1, REG_PERIOD, 32'h00000002);
        dev_u.got.delete();
        ahb(1'b1, REG_CTRL, 32'h00000008);
        txwait(10);
        ahb(1'b1, REG_CTRL, 32'h00000000);
        chk("auto_count", 32'h00000001, 32'(dev_u.got.size() >= 10));
        foreach (q[i]) chk("auto_byte", {24'h000000, q[i]}, {24'h000000, dev_u.got[i + 5]});
        $display("done auto");
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h00000000;
        out_wr_en = 1'b0;
        out_wr_addr = 8'h00;
        out_wr_data = 8'h00;
        in_rd_addr = 8'h00;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs;
        t_timeout;
        t_crc;
        t_length;
        t_delim;
        t_tx;
        t_auto;
        test_done;
    end
    // About six times the expected run length
    initial begin
        repeat (40000) @(posedge hclk);
        failures++;
        test_done;
    end
endmodule // serial_frame_exchange_bridge_test

bind serial_frame_exchange_bridge serial_frame_exchange_asserts chk_u (.hclk, .hresetn,
    .hreadyout, .hresp, .rx_ready, .tx_valid, .tx_data, .tx_ready, .in_rd_addr, .in_rd_data);
